//--- design/msx_responder.sv
/*
 * query responder: decides between normal answer, silence and exception
 * answer for each query, and holds the clock register group.
 * assumes framing and check sums are done outside; the query arrives
 * parsed, with error flags, as a one-cycle valid while ready is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msx_regs.svh"

module msx_responder (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// parsed query from the framer
	input wire logic qry_valid,
	input wire logic qry_comm_err,
	input wire logic qry_check_err,
	input wire msx_pkg::msx_query_t qry,
	output logic qry_ready,
	output logic qry_dropped,
	// controller state
	input wire logic dev_busy,
	input wire logic dev_fault,
	input wire logic dev_nak,
	// answer to the framer
	output logic rsp_valid,
	output msx_pkg::msx_resp_t rsp
);

	// ************************************************************
	// state and storage
	// ************************************************************
	msx_pkg::msx_state_t state_reg;
	msx_pkg::msx_state_t state_next;
	msx_pkg::msx_query_t qry_reg;
	logic busy_reg;
	logic fault_reg;
	logic nak_reg;
	logic [31:0] field_reg [0:6];
	msx_pkg::msx_resp_t rsp_reg;
	msx_pkg::msx_resp_t rsp_next;

	msx_pkg::msx_field_t field;
	logic hit;
	logic value_ok;
	logic fc_known;
	logic is_write;
	logic do_write;
	logic [7:0] exc_code;
	logic accept;
	logic accept_err;

	msx_field_chk u_chk (
		.addr(qry_reg.addr),
		.value(qry_reg.float_value),
		.field(field),
		.hit(hit),
		.value_ok(value_ok)
	);

	function automatic logic fc_supported(input logic [7:0] fc);
		fc_supported = !fc[`MSX_FC_MSB] && ((fc == `MSX_FC_READ)
			|| (fc == `MSX_FC_WRITE) || (fc == `MSX_FC_FILE));
	endfunction

	function automatic logic [31:0] field_read(input logic [31:0] v,
		input msx_pkg::msx_field_t f);
		field_read = (f == msx_pkg::MSX_F_MONTH) ? (v & `MSX_MONTH_MASK) : v;
	endfunction

	// ************************************************************
	// query intake
	// ************************************************************
	assign qry_ready = (state_reg == msx_pkg::MSX_IDLE);
	assign accept = qry_valid && qry_ready;
	assign accept_err = qry_comm_err || qry_check_err;
	// an errored query never leaves idle, so nothing is ever sent for it
	assign qry_dropped = accept && accept_err;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			qry_reg <= '0;
			busy_reg <= 1'b0;
			fault_reg <= 1'b0;
			nak_reg <= 1'b0;
		end else if (accept) begin
			qry_reg <= qry;
			busy_reg <= dev_busy;
			fault_reg <= dev_fault;
			nak_reg <= dev_nak;
		end
	end

	// ************************************************************
	// sequencing
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			msx_pkg::MSX_IDLE:
				if (accept && !accept_err) begin
					state_next = msx_pkg::MSX_EVAL;
				end
			msx_pkg::MSX_EVAL:
				state_next = msx_pkg::MSX_RESP;
			msx_pkg::MSX_RESP:
				state_next = msx_pkg::MSX_IDLE;
			default:
				state_next = msx_pkg::MSX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= msx_pkg::MSX_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// decision: first matching condition wins
	// ************************************************************
	assign fc_known = fc_supported(qry_reg.fcode);
	assign is_write = (qry_reg.fcode == `MSX_FC_WRITE);

	always_comb begin
		exc_code = `MSX_EXC_NONE;
		if (!fc_known) begin
			exc_code = `MSX_EXC_FUNC;
		end else if (busy_reg) begin
			exc_code = `MSX_EXC_BUSY;
		end else if (fault_reg) begin
			exc_code = `MSX_EXC_FAIL;
		end else if (nak_reg) begin
			exc_code = `MSX_EXC_NAK;
		end else if (!hit) begin
			exc_code = `MSX_EXC_ADDR;
		end else if ((qry_reg.fcode == `MSX_FC_FILE)
			&& (qry_reg.count > `MSX_BUF_WORDS)) begin
			exc_code = `MSX_EXC_OVF;
		end else if ((qry_reg.fcode == `MSX_FC_READ)
			&& (qry_reg.count != `MSX_SINGLE)) begin
			// the group answers one register per read
			exc_code = `MSX_EXC_VALUE;
		end else if (is_write && !value_ok) begin
			exc_code = `MSX_EXC_VALUE;
		end
	end

	assign do_write = (state_reg == msx_pkg::MSX_EVAL) && is_write
		&& (exc_code == `MSX_EXC_NONE);

	always_comb begin
		rsp_next = rsp_reg;
		if (state_reg == msx_pkg::MSX_EVAL) begin
			if (exc_code != `MSX_EXC_NONE) begin
				rsp_next.fcode = qry_reg.fcode | `MSX_FC_EXC_BIT;
				rsp_next.exc = 1'b1;
				rsp_next.data = {24'h000000, exc_code};
			end else begin
				rsp_next.fcode = qry_reg.fcode;
				rsp_next.exc = 1'b0;
				rsp_next.data = is_write ? qry_reg.float_value
					: field_read(field_reg[field], field);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign rsp = rsp_reg;
	assign rsp_valid = (state_reg == msx_pkg::MSX_RESP);

	// ************************************************************
	// clock register group
	// ************************************************************
	// the zone offset is stored only; nothing here reads it back into time
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			field_reg[msx_pkg::MSX_F_HOUR] <= `MSX_RST_HOUR;
			field_reg[msx_pkg::MSX_F_MINUTE] <= `MSX_RST_MINUTE;
			field_reg[msx_pkg::MSX_F_SECOND] <= `MSX_RST_SECOND;
			field_reg[msx_pkg::MSX_F_DAY] <= `MSX_RST_DAY;
			field_reg[msx_pkg::MSX_F_YEAR] <= `MSX_RST_YEAR;
			field_reg[msx_pkg::MSX_F_ZONE] <= `MSX_RST_ZONE;
			field_reg[msx_pkg::MSX_F_MONTH] <= `MSX_RST_MONTH;
		end else if (do_write) begin
			field_reg[field] <= qry_reg.float_value;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	silent_drop_a: assert property (
		accept && accept_err |=> !rsp_valid [*2])
		else $error("errored query was answered");

	answer_time_a: assert property (
		accept && !accept_err |-> ##2 rsp_valid ##1 !rsp_valid)
		else $error("clean query not answered in two cycles");

	echo_fcode_a: assert property (
		rsp_valid && !rsp.exc |-> rsp.fcode == qry_reg.fcode
			&& !rsp.fcode[`MSX_FC_MSB])
		else $error("normal answer does not echo function code");

	exc_fcode_a: assert property (
		rsp_valid && rsp.exc |-> rsp.fcode == (qry_reg.fcode
			| `MSX_FC_EXC_BIT) && rsp.data[31:8] == 24'h000000)
		else $error("exception answer malformed");

	bad_func_a: assert property (
		state_reg == msx_pkg::MSX_EVAL && !fc_known
			|=> rsp_valid && rsp.exc && rsp.data[7:0] == `MSX_EXC_FUNC)
		else $error("unsupported function not answered 01");

	busy_code_a: assert property (
		accept && !accept_err && dev_busy && fc_supported(qry.fcode)
			|-> ##2 rsp.data[7:0] == `MSX_EXC_BUSY)
		else $error("busy not answered 06");

	bad_addr_a: assert property (
		state_reg == msx_pkg::MSX_EVAL && fc_known && !busy_reg
			&& !fault_reg && !nak_reg && !hit
			|=> rsp.exc && rsp.data[7:0] == `MSX_EXC_ADDR)
		else $error("missing register not answered 02");

	buf_ovf_a: assert property (
		rsp_valid && rsp.exc && rsp.data[7:0] == `MSX_EXC_OVF
			|-> qry_reg.fcode == `MSX_FC_FILE
			&& qry_reg.count > `MSX_BUF_WORDS)
		else $error("09 given outside function 20 overflow");

	value_keep_a: assert property (
		state_reg == msx_pkg::MSX_EVAL && is_write && hit && !value_ok
			&& !busy_reg && !fault_reg && !nak_reg
			|=> $stable(field_reg[field]) ##0 rsp.exc
			&& rsp.data[7:0] == `MSX_EXC_VALUE)
		else $error("bad clock write not refused");

	hour_range_a: assert property (
		field_reg[msx_pkg::MSX_F_HOUR] <= `MSX_HOUR_MAX
			&& field_reg[msx_pkg::MSX_F_YEAR] >= `MSX_YEAR_MIN)
		else $error("clock field out of range");

	fault_code_a: assert property (
		state_reg == msx_pkg::MSX_EVAL && fc_known && !busy_reg
			&& fault_reg
			|=> rsp.exc && rsp.data[7:0] == `MSX_EXC_FAIL)
		else $error("device fault not answered 04");

	nak_code_a: assert property (
		state_reg == msx_pkg::MSX_EVAL && fc_known && !busy_reg
			&& !fault_reg && nak_reg
			|=> rsp.exc && rsp.data[7:0] == `MSX_EXC_NAK)
		else $error("unprocessable query not answered 07");

	write_land_a: assert property (
		do_write |=> field_reg[field] == qry_reg.float_value)
		else $error("accepted clock write not stored");

	write_echo_a: assert property (
		rsp_valid && !rsp.exc && is_write
			|-> rsp.data == qry_reg.float_value)
		else $error("write answer does not echo value");

	field_range_a: assert property (
		field_reg[msx_pkg::MSX_F_MONTH] <= `MSX_MONTH_MAX
			&& field_reg[msx_pkg::MSX_F_DAY] >= `MSX_DAY_MIN
			&& field_reg[msx_pkg::MSX_F_DAY] <= `MSX_DAY_MAX)
		else $error("month or day field out of range");

	normal_read_c: cover property (
		rsp_valid && !rsp.exc && qry_reg.fcode == `MSX_FC_READ);
	good_write_c: cover property (do_write);
	exception_c: cover property (rsp_valid && rsp.exc);
	dropped_c: cover property (qry_dropped);
	busy_reject_c: cover property (
		rsp_valid && rsp.exc && rsp.data[7:0] == `MSX_EXC_BUSY);

endmodule

`default_nettype wire

//--- design/msx_regs.svh
/*
 * constants of the query responder: clock group addresses, function and
 * exception codes, field limits and reset values.
 * assumes nothing; definitions only.
 */
`ifndef MSX_REGS_SVH
`define MSX_REGS_SVH

// ************************************************************
// clock group register addresses
// ************************************************************
`define MSX_ADR_HOUR 16'h4010
`define MSX_ADR_MINUTE 16'h4011
`define MSX_ADR_SECOND 16'h4012
`define MSX_ADR_DAY 16'h4013
`define MSX_ADR_YEAR 16'h4014
`define MSX_ADR_ZONE 16'h4015
`define MSX_ADR_MONTH 16'h4089

// ************************************************************
// function codes
// ************************************************************
`define MSX_FC_READ 8'h03
`define MSX_FC_WRITE 8'h06
`define MSX_FC_FILE 8'h14
`define MSX_FC_EXC_BIT 8'h80
`define MSX_FC_MSB 7

// ************************************************************
// exception codes
// ************************************************************
`define MSX_EXC_FUNC 8'h01
`define MSX_EXC_ADDR 8'h02
`define MSX_EXC_VALUE 8'h03
`define MSX_EXC_FAIL 8'h04
`define MSX_EXC_BUSY 8'h06
`define MSX_EXC_NAK 8'h07
`define MSX_EXC_OVF 8'h09
`define MSX_EXC_NONE 8'h00

// ************************************************************
// field limits
// ************************************************************
`define MSX_HOUR_MAX 32'h00000017
`define MSX_MINSEC_MAX 32'h0000003B
`define MSX_DAY_MIN 32'h00000001
`define MSX_DAY_MAX 32'h0000001F
`define MSX_MONTH_MAX 32'h0000000C
`define MSX_YEAR_MIN 32'h000007D5
`define MSX_YEAR_MAX 32'h00000833
`define MSX_ZONE_MIN 32'hFFFFFB50
`define MSX_ZONE_MAX 32'h00000514
`define MSX_ZERO 32'h00000000
`define MSX_MONTH_MASK 32'h0000FFFF
`define MSX_SINGLE 16'h0001
`define MSX_BUF_WORDS 16'h0004

// ************************************************************
// reset values
// ************************************************************
`define MSX_RST_HOUR 32'h00000000
`define MSX_RST_MINUTE 32'h00000000
`define MSX_RST_SECOND 32'h00000000
`define MSX_RST_DAY 32'h00000001
`define MSX_RST_YEAR 32'h000007D5
`define MSX_RST_ZONE 32'h00000000
`define MSX_RST_MONTH 32'h00000000

`endif

//--- design/msx_pkg.sv
/*
 * types of the query responder: query and response carriers, states,
 * clock field index.
 * assumes the constants header is included by the users.
 */
package msx_pkg;

	typedef struct packed {
		logic [7:0] fcode;
		logic [15:0] addr;
		logic [15:0] count;
		logic [31:0] float_value;
	} msx_query_t;

	typedef struct packed {
		logic [7:0] fcode;
		logic exc;
		logic [31:0] data;
	} msx_resp_t;

	typedef enum logic [1:0] {
		MSX_IDLE = 2'h0,
		MSX_EVAL = 2'h1,
		MSX_RESP = 2'h3
	} msx_state_t;

	typedef enum logic [2:0] {
		MSX_F_HOUR = 3'h0,
		MSX_F_MINUTE = 3'h1,
		MSX_F_SECOND = 3'h2,
		MSX_F_DAY = 3'h3,
		MSX_F_YEAR = 3'h4,
		MSX_F_ZONE = 3'h5,
		MSX_F_MONTH = 3'h6
	} msx_field_t;

endpackage

//--- design/msx_field_chk.sv
/*
 * address decode and range check for the clock register group.
 * assumes a purely combinational use by the responder.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msx_regs.svh"

module msx_field_chk (
	// register address and value under test
	input wire logic [15:0] addr,
	input wire logic [31:0] value,
	// decode results
	output msx_pkg::msx_field_t field,
	output logic hit,
	output logic value_ok
);

	function automatic logic in_span(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		in_span = (v >= lo) && (v <= hi);
	endfunction

	always_comb begin
		hit = 1'b1;
		field = msx_pkg::MSX_F_HOUR;
		unique case (addr)
			`MSX_ADR_HOUR: field = msx_pkg::MSX_F_HOUR;
			`MSX_ADR_MINUTE: field = msx_pkg::MSX_F_MINUTE;
			`MSX_ADR_SECOND: field = msx_pkg::MSX_F_SECOND;
			`MSX_ADR_DAY: field = msx_pkg::MSX_F_DAY;
			`MSX_ADR_YEAR: field = msx_pkg::MSX_F_YEAR;
			`MSX_ADR_ZONE: field = msx_pkg::MSX_F_ZONE;
			`MSX_ADR_MONTH: field = msx_pkg::MSX_F_MONTH;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		unique case (field)
			msx_pkg::MSX_F_HOUR:
				value_ok = in_span(value, `MSX_ZERO, `MSX_HOUR_MAX);
			msx_pkg::MSX_F_MINUTE,
			msx_pkg::MSX_F_SECOND:
				value_ok = in_span(value, `MSX_ZERO, `MSX_MINSEC_MAX);
			msx_pkg::MSX_F_DAY:
				value_ok = in_span(value, `MSX_DAY_MIN, `MSX_DAY_MAX);
			msx_pkg::MSX_F_YEAR:
				value_ok = in_span(value, `MSX_YEAR_MIN, `MSX_YEAR_MAX);
			msx_pkg::MSX_F_ZONE:
				value_ok = ($signed(value) >= $signed(`MSX_ZONE_MIN))
					&& ($signed(value) <= $signed(`MSX_ZONE_MAX));
			msx_pkg::MSX_F_MONTH:
				value_ok = in_span(value, `MSX_ZERO, `MSX_MONTH_MAX);
			default:
				value_ok = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

//--- sim/msx_master_model.sv
/*
 * behavioural link master: puts one parsed query on the responder's input,
 * then waits a bounded time for the answer.
 * assumes the bench calls send from one process only, between clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msx_regs.svh"

module msx_master_model (
	// clock
	input wire logic clk_sys,
	// query towards the responder
	output logic qry_valid,
	output logic qry_comm_err,
	output logic qry_check_err,
	output msx_pkg::msx_query_t qry,
	input wire logic qry_ready,
	input wire logic qry_dropped,
	// answer from the responder
	input wire logic rsp_valid,
	input wire msx_pkg::msx_resp_t rsp
);
	localparam int REPLY_WAIT = 6;

	initial begin
		qry_valid = 1'b0;
		qry_comm_err = 1'b0;
		qry_check_err = 1'b0;
		qry = '0;
	end

	task automatic send(input msx_pkg::msx_query_t q, input logic ce,
		input logic ke, output logic got, output logic drop,
		output msx_pkg::msx_resp_t r, output logic is_exc);
		int n;
		got = 1'b0;
		r = '0;
		n = 0;
		@(negedge clk_sys);
		qry <= q;
		qry_comm_err <= ce;
		qry_check_err <= ke;
		qry_valid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (qry_ready !== 1'b1 && n < 20);
		drop = qry_dropped;
		@(negedge clk_sys);
		qry_valid <= 1'b0;
		qry_comm_err <= 1'b0;
		qry_check_err <= 1'b0;
		// released lines carry garbage, not the last query
		qry <= ~q;
		// a missing answer is a time-out for this query only
		for (n = 0; n < REPLY_WAIT && !got; n++) begin
			if (rsp_valid === 1'b1) begin
				got = 1'b1;
				r = rsp;
			end else begin
				@(negedge clk_sys);
			end
		end
		is_exc = got & r.fcode[`MSX_FC_MSB];
	endtask
endmodule

`default_nettype wire

//--- sim/msx_responder_bench.sv
/*
 * self-checking bench of the query responder: corner cases, then random
 * queries, each compared with an answer worked out here.
 * assumes the design package, constants header and master model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msx_regs.svh"

module msx_responder_bench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic dev_busy = 1'b0;
	logic dev_fault = 1'b0;
	logic dev_nak = 1'b0;
	logic qry_valid, qry_comm_err, qry_check_err, qry_ready, qry_dropped;
	logic rsp_valid;
	msx_pkg::msx_query_t qry;
	msx_pkg::msx_resp_t rsp;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	integer seed = 32'h788E4D05;
	logic [15:0] adr_tab [0:7] = '{16'h4010, 16'h4011, 16'h4012, 16'h4013,
		16'h4014, 16'h4015, 16'h4089, 16'h4016};
	logic [31:0] lo_tab [0:6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h7D5,
		32'hFFFFFB50, 32'h0};
	logic [31:0] hi_tab [0:6] = '{32'h17, 32'h3B, 32'h3B, 32'h1F, 32'h833,
		32'h514, 32'hC};
	logic [31:0] rst_tab [0:6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h7D5,
		32'h0, 32'h0};
	logic [31:0] shadow [0:6];
	logic [7:0] fc_tab [0:5] = '{8'h03, 8'h06, 8'h14, 8'h06, 8'h03, 8'h01};

	always #12.5 clk_sys = ~clk_sys;

	msx_responder DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.qry_valid(qry_valid), .qry_comm_err(qry_comm_err),
		.qry_check_err(qry_check_err), .qry(qry), .qry_ready(qry_ready),
		.qry_dropped(qry_dropped), .dev_busy(dev_busy),
		.dev_fault(dev_fault), .dev_nak(dev_nak), .rsp_valid(rsp_valid),
		.rsp(rsp));

	msx_master_model MM (.clk_sys(clk_sys), .qry_valid(qry_valid),
		.qry_comm_err(qry_comm_err), .qry_check_err(qry_check_err),
		.qry(qry), .qry_ready(qry_ready), .qry_dropped(qry_dropped),
		.rsp_valid(rsp_valid), .rsp(rsp));

	// ************************************************************
	// expectation and checking
	// ************************************************************
	function automatic int field_of(input logic [15:0] a);
		for (int i = 0; i < 7; i++) if (adr_tab[i] === a) return i;
		return 7;
	endfunction

	function automatic logic [7:0] exc_code(input msx_pkg::msx_query_t q);
		int i;
		i = field_of(q.addr);
		if (q.fcode[7] || !(q.fcode inside {`MSX_FC_READ, `MSX_FC_WRITE,
			`MSX_FC_FILE})) return `MSX_EXC_FUNC;
		if (dev_busy) return `MSX_EXC_BUSY;
		if (dev_fault) return `MSX_EXC_FAIL;
		if (dev_nak) return `MSX_EXC_NAK;
		if (i == 7) return `MSX_EXC_ADDR;
		if (q.fcode == `MSX_FC_FILE && q.count > `MSX_BUF_WORDS)
			return `MSX_EXC_OVF;
		if (q.fcode == `MSX_FC_READ && q.count != `MSX_SINGLE)
			return `MSX_EXC_VALUE;
		if (q.fcode == `MSX_FC_WRITE &&
			($signed(q.float_value) < $signed(lo_tab[i]) ||
			$signed(q.float_value) > $signed(hi_tab[i])))
			return `MSX_EXC_VALUE;
		return 8'h00;
	endfunction

	task automatic check(input string what, input logic [40:0] seen,
		input logic [40:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic run(input logic [7:0] fc, input logic [15:0] a,
		input logic [15:0] cnt, input logic [31:0] v, input logic ce,
		input logic ke);
		msx_pkg::msx_query_t q;
		msx_pkg::msx_resp_t r, e;
		logic got, drop, ex, err;
		logic [7:0] c;
		int i;
		q = '{fcode: fc, addr: a, count: cnt, float_value: v};
		i = field_of(a);
		c = exc_code(q);
		err = ce | ke;
		if (c != 8'h00) e = '{fc | `MSX_FC_EXC_BIT, 1'b1, {24'h000000, c}};
		else if (fc == `MSX_FC_WRITE) e = '{fc, 1'b0, v};
		// only the month reads back in its narrow width
		else if (i == 6) e = '{fc, 1'b0, shadow[i] & `MSX_MONTH_MASK};
		else e = '{fc, 1'b0, shadow[i]};
		MM.send(q, ce, ke, got, drop, r, ex);
		check("answered", {40'h0, got}, {40'h0, ~err});
		check("dropped", {40'h0, drop}, {40'h0, err});
		if (!err) begin
			check("response", r, e);
			check("exc flag", {40'h0, ex}, {40'h0, c != 8'h00});
		end
		// refused writes keep the stored value
		if (!err && c == 8'h00 && fc == `MSX_FC_WRITE) shadow[i] = v;
	endtask

	task automatic do_reset;
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 7; i++) shadow[i] = rst_tab[i];
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int k;
		logic [31:0] v;
		logic [31:0] lst [0:3];
		logic [7:0] fc;
		do_reset();
		for (int i = 0; i < 7; i++) run(8'h03, adr_tab[i], 16'h1, 0, 0, 0);
		for (int i = 0; i < 7; i++) begin
			lst = '{lo_tab[i] - 1, lo_tab[i], hi_tab[i] + 1, hi_tab[i]};
			for (int j = 0; j < 4; j++) begin
				run(8'h06, adr_tab[i], 16'h1, lst[j], 0, 0);
				run(8'h03, adr_tab[i], 16'h1, 0, 0, 0);
			end
		end
		foreach (lst[j]) run(8'h14, 16'h4012, 16'h3 + j, 0, 0, 0);
		run(8'h03, 16'h4012, 16'h2, 0, 0, 0);
		run(8'h06, 16'h4088, 16'h1, 0, 0, 0);
		run(8'h03, 16'h4016, 16'h1, 0, 0, 0);
		foreach (fc_tab[j]) run(fc_tab[j] ^ 8'h80, 16'h4010, 16'h1, 0, 0, 0);
		run(8'h10, 16'h4010, 16'h1, 0, 0, 0);
		for (int j = 1; j < 8; j++) begin
			{dev_nak, dev_fault, dev_busy} = j[2:0];
			run(8'h03, 16'h4016, 16'h1, 0, 0, 0);
		end
		{dev_nak, dev_fault, dev_busy} = 3'h0;
		run(8'h06, 16'h4010, 16'h1, 32'h5, 1, 0);
		run(8'h06, 16'h4010, 16'h1, 32'h6, 0, 1);
		run(8'h83, 16'h4016, 16'h1, 32'h7, 1, 1);
		run(8'h03, 16'h4010, 16'h1, 0, 0, 0);
		for (int n = 0; n < 200; n++) begin
			k = $unsigned($random(seed)) % 8;
			fc = fc_tab[$unsigned($random(seed)) % 6];
			v = lo_tab[k % 7] - 1 + ($unsigned($random(seed)) %
				(hi_tab[k % 7] - lo_tab[k % 7] + 3));
			dev_busy = ($unsigned($random(seed)) % 16) == 0;
			dev_fault = ($unsigned($random(seed)) % 16) == 0;
			dev_nak = ($unsigned($random(seed)) % 16) == 0;
			run(fc, (k == 7) ? 16'($random(seed)) : adr_tab[k],
				(fc == 8'h14) ? 16'(1 + $unsigned($random(seed)) % 5) :
				16'(1 + (($unsigned($random(seed)) % 8) == 0)), v,
				($unsigned($random(seed)) % 10) == 0,
				($unsigned($random(seed)) % 10) == 0);
		end
		{dev_nak, dev_fault, dev_busy} = 3'h0;
		do_reset();
		for (int i = 0; i < 7; i++) run(8'h14, adr_tab[i], 16'h1, 0, 0, 0);
		complete_run();
	end
endmodule

`default_nettype wire
